// ==== shared/sac_pkg.sv ====
// Function
// - ten-bit successive approximation result, right-justified over high and low result registers
// - five-bit channel select field picks the sample-and-hold source
// - die temperature sensor sits on channel 13
// - temperature sensor always powered, no enable bit
// - clock select 001 /8, 101 /16, 010 /32, 110 /64, x11 rc clock
// - rc conversion clock is internal oscillator divided by 16
// - divider selections follow the system clock, rc source does not
// - one full conversion takes eleven conversion-clock periods
// - converter enabled only while converter_on set; writing go while already on and idle starts a conversion
// - completion clears go, sets done flag, loads result registers
// - done flag set at every completion regardless of irq enable
// - flag and enable both set request interrupt, and wake in sleep
// - reference select at bit 0 of control b, reset picks 4.096V regulator
// - clearing go mid-conversion aborts and keeps previous result
// - after abort wait two conversion clocks then start acquisition automatically
// - reset returns all registers to reset values, converter off
// - factory 10-bit temperature calibration at 30 degrees readable by software
// - go reads 0 when idle and 1 throughout a conversion
package sac_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] SAC_ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] SAC_ADDR_CTRL_B = 4'h1;
  localparam logic [3:0] SAC_ADDR_RES_HI = 4'h2;
  localparam logic [3:0] SAC_ADDR_RES_LO = 4'h3;
  localparam logic [3:0] SAC_ADDR_FLAG = 4'h4;
  localparam logic [3:0] SAC_ADDR_IRQEN = 4'h5;
  localparam logic [3:0] SAC_ADDR_CAL_HI = 4'h6;
  localparam logic [3:0] SAC_ADDR_CAL_LO = 4'h7;
  localparam logic [3:0] SAC_ADDR_STATUS = 4'h8;
  localparam logic [15:0] SAC_CAL_NVM_ADDR = 16'h2084;

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int SAC_BIT_ON = 0;
  localparam int SAC_BIT_GO = 1;
  localparam int SAC_CHS_LSB = 2;
  localparam int SAC_CS_LSB = 4;
  localparam int SAC_BIT_REF = 0;
  localparam logic [4:0] SAC_CH_TEMP = 5'h0D;
  localparam logic [2:0] SAC_CS_DIV8 = 3'h1;
  localparam logic [2:0] SAC_CS_DIV16 = 3'h5;
  localparam logic [2:0] SAC_CS_DIV32 = 3'h2;
  localparam logic [2:0] SAC_CS_DIV64 = 3'h6;
  localparam logic [1:0] SAC_CS_RC_LOW = 2'h3;
  localparam logic [6:0] SAC_DIV8_M1 = 7'h07;
  localparam logic [6:0] SAC_DIV16_M1 = 7'h0F;
  localparam logic [6:0] SAC_DIV32_M1 = 7'h1F;
  localparam logic [6:0] SAC_DIV64_M1 = 7'h3F;
  localparam logic [3:0] SAC_RC_DIV_M1 = 4'hF;
  localparam logic [3:0] SAC_CONV_TAD = 4'hB;
  localparam logic [3:0] SAC_ABORT_TAD = 4'h2;
  localparam logic [7:0] SAC_RESET_BYTE = 8'h00;

  typedef enum logic [1:0] {SAC_IDLE, SAC_CONV, SAC_WAIT} sac_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sac_bus_t;

  typedef struct packed {
    logic cmp_start;
    logic [3:0] cmp_bit;
    logic cmp_valid;
  } sac_ana_t;
endpackage

// ==== rtl/sac_tad_gen.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// conversion clock enable generator
// ------------------------------------------------------------------
module sac_tad_gen
  import sac_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic [2:0] clk_sel,
  input wire logic rc_osc_tick,
  output logic tad_tick
);
  typedef struct packed {
    logic [6:0] cnt;
    logic [3:0] rc_cnt;
  } sac_tad_st_t;

  sac_tad_st_t st_r;
  sac_tad_st_t st_nxt;
  logic [6:0] lim;
  logic use_rc;

  always_comb
  begin
    use_rc = (clk_sel[1:0] == SAC_CS_RC_LOW);
    unique case (clk_sel)
      SAC_CS_DIV8: lim = SAC_DIV8_M1;
      SAC_CS_DIV16: lim = SAC_DIV16_M1;
      SAC_CS_DIV32: lim = SAC_DIV32_M1;
      SAC_CS_DIV64: lim = SAC_DIV64_M1;
      // reserved codes fall back to the slowest safe rate
      default: lim = SAC_DIV64_M1;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    tad_tick = 1'b0;
    if (!run)
    begin
      st_nxt.cnt = '0;
      st_nxt.rc_cnt = '0;
    end
    else if (use_rc)
    begin
      // rc path ignores mclk rate, only the oscillator tick counts
      if (rc_osc_tick)
      begin
        if (st_r.rc_cnt == SAC_RC_DIV_M1)
        begin
          st_nxt.rc_cnt = '0;
          tad_tick = 1'b1;
        end
        else
          st_nxt.rc_cnt = st_r.rc_cnt + 4'h1;
      end
    end
    else if (st_r.cnt >= lim)
    begin
      st_nxt.cnt = '0;
      tad_tick = 1'b1;
    end
    else
      st_nxt.cnt = st_r.cnt + 7'h01;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule

// ==== rtl/sac_ctrl.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// successive approximation converter control
// ------------------------------------------------------------------
module sac_ctrl
  import sac_pkg::*;
#(
  parameter int RES_W = 10,
  parameter logic [9:0] CAL_30C = 10'h200
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire sac_bus_t bus,
  output logic [7:0] rdata,
  input wire logic rc_osc_tick,
  input wire logic sleep_mode,
  input wire logic cmp_hi,
  output logic [4:0] channel_select_field,
  output logic die_temperature_channel,
  output logic temp_sensor_on,
  output logic reference_select,
  output logic converter_on,
  output logic sample_hold,
  output logic [RES_W-1:0] dac_code,
  output logic irq_req,
  output logic wake_req
);
  typedef struct packed {
    sac_state_t state;
    logic on;
    logic go;
    logic [4:0] chs;
    logic [2:0] cs;
    logic ref_sel;
    logic done_flag;
    logic irq_en;
    logic [RES_W-1:0] res;
    logic [RES_W-1:0] sar;
    logic [3:0] tad_cnt;
    logic tad_rst;
    logic [7:0] rdata;
  } sac_st_t;

  sac_st_t st_r;
  sac_st_t st_nxt;
  logic tad_tick;
  logic wr_a;
  logic wr_flag;

  // ----------------------------------------------------------------
  // conversion clock
  // ----------------------------------------------------------------
  sac_tad_gen u_tad
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .run(st_r.on && st_r.state != SAC_IDLE && !st_r.tad_rst),
    .clk_sel(st_r.cs),
    .rc_osc_tick(rc_osc_tick),
    .tad_tick(tad_tick)
  );

  assign wr_a = bus.wr && bus.addr == SAC_ADDR_CTRL_A;
  assign wr_flag = bus.wr && bus.addr == SAC_ADDR_FLAG;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tad_rst = 1'b0;
    // register writes
    if (wr_a)
    begin
      st_nxt.on = bus.wdata[SAC_BIT_ON];
      st_nxt.chs = bus.wdata[SAC_CHS_LSB +: 5];
      // go only takes when converter was already on
      st_nxt.go = bus.wdata[SAC_BIT_GO] && bus.wdata[SAC_BIT_ON] && st_r.on;
    end
    if (bus.wr && bus.addr == SAC_ADDR_CTRL_B)
    begin
      st_nxt.cs = bus.wdata[SAC_CS_LSB +: 3];
      st_nxt.ref_sel = bus.wdata[SAC_BIT_REF];
    end
    if (bus.wr && bus.addr == SAC_ADDR_IRQEN)
      st_nxt.irq_en = bus.wdata[0];
    // software clear of the flag; completion below wins
    if (wr_flag)
      st_nxt.done_flag = bus.wdata[0];

    unique case (st_r.state)
      SAC_IDLE:
      begin
        if (wr_a && st_nxt.go)
        begin
          st_nxt.state = SAC_CONV;
          st_nxt.tad_cnt = '0;
          st_nxt.sar = '0;
        end
      end
      SAC_CONV:
      begin
        if (!st_nxt.on)
        begin
          st_nxt.state = SAC_IDLE;
          st_nxt.go = 1'b0;
        end
        else if (!st_nxt.go)
        begin
          // aborted: result kept
          st_nxt.state = SAC_WAIT;
          st_nxt.tad_cnt = '0;
          // restart the divider, else a part-spent period shortens the wait
          st_nxt.tad_rst = 1'b1;
        end
        else if (tad_tick)
        begin
          st_nxt.tad_cnt = st_r.tad_cnt + 4'h1;
          // tad 0 samples, tads 1..10 resolve one bit each
          if (st_r.tad_cnt != 4'h0)
            st_nxt.sar[RES_W[3:0] - st_r.tad_cnt] = cmp_hi;
          if (st_r.tad_cnt == SAC_CONV_TAD - 4'h1)
          begin
            st_nxt.state = SAC_IDLE;
            st_nxt.go = 1'b0;
            st_nxt.done_flag = 1'b1;
            st_nxt.res = st_nxt.sar;
          end
        end
      end
      SAC_WAIT:
      begin
        // a start during the wait is refused, so go never sticks at 1 in idle
        st_nxt.go = 1'b0;
        if (!st_nxt.on)
          st_nxt.state = SAC_IDLE;
        else if (tad_tick)
        begin
          st_nxt.tad_cnt = st_r.tad_cnt + 4'h1;
          // acquisition restarts on the held channel
          if (st_r.tad_cnt == SAC_ABORT_TAD - 4'h1)
            st_nxt.state = SAC_IDLE;
        end
      end
      default:
        st_nxt.state = SAC_IDLE;
    endcase

    // read port, data one cycle after the strobe
    st_nxt.rdata = '0;
    if (bus.rd)
    begin
      unique case (bus.addr)
        SAC_ADDR_CTRL_A:
          st_nxt.rdata = {1'b0, st_r.chs, st_r.go, st_r.on};
        SAC_ADDR_CTRL_B:
          st_nxt.rdata = {1'b0, st_r.cs, 3'h0, st_r.ref_sel};
        SAC_ADDR_RES_HI:
          st_nxt.rdata = {6'h00, st_r.res[9:8]};
        SAC_ADDR_RES_LO:
          st_nxt.rdata = st_r.res[7:0];
        SAC_ADDR_FLAG:
          st_nxt.rdata = {7'h00, st_r.done_flag};
        SAC_ADDR_IRQEN:
          st_nxt.rdata = {7'h00, st_r.irq_en};
        SAC_ADDR_CAL_HI:
          st_nxt.rdata = {6'h00, CAL_30C[9:8]};
        SAC_ADDR_CAL_LO:
          st_nxt.rdata = CAL_30C[7:0];
        SAC_ADDR_STATUS:
          st_nxt.rdata = {6'h00, st_r.state};
        default:
          st_nxt.rdata = SAC_RESET_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata = st_r.rdata;
  assign channel_select_field = st_r.chs;
  assign die_temperature_channel = (st_r.chs == SAC_CH_TEMP);
  assign temp_sensor_on = 1'b1;
  assign reference_select = st_r.ref_sel;
  assign converter_on = st_r.on;
  // sampling while enabled and not resolving bits
  assign sample_hold = st_r.on && !(st_r.state == SAC_CONV && st_r.tad_cnt != 4'h0);
  // trial code: settled bits plus the bit under test
  always_comb
  begin
    dac_code = st_r.sar;
    if (st_r.state == SAC_CONV && st_r.tad_cnt != 4'h0)
      dac_code[RES_W[3:0] - st_r.tad_cnt] = 1'b1;
  end
  assign irq_req = st_r.done_flag && st_r.irq_en;
  assign wake_req = irq_req && sleep_mode;
endmodule

// ==== tb/sac_ctrl_assertions.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------------
// port checks
// ------------------------------------------------------------------
module sac_ctrl_chk
  import sac_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire sac_bus_t bus,
  input wire logic [7:0] rdata,
  input wire logic sleep_mode,
  input wire logic [4:0] channel_select_field,
  input wire logic die_temperature_channel,
  input wire logic reference_select,
  input wire logic converter_on,
  input wire logic irq_req,
  input wire logic wake_req
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_temp_chan:
    assert property (die_temperature_channel == (channel_select_field == SAC_CH_TEMP))
    else $error("temperature channel decode wrong");
  a_chan_write:
    assert property (bus.wr && bus.addr == SAC_ADDR_CTRL_A |=> channel_select_field == $past(bus.wdata[6:2]))
    else $error("channel field not taken");
  a_on_write:
    assert property (bus.wr && bus.addr == SAC_ADDR_CTRL_A |=> converter_on == $past(bus.wdata[0]))
    else $error("converter enable not taken");
  a_ref_write:
    assert property (bus.wr && bus.addr == SAC_ADDR_CTRL_B |=> reference_select == $past(bus.wdata[0]))
    else $error("reference select not taken");
  a_wake_sleep:
    assert property (wake_req == (irq_req && sleep_mode))
    else $error("wake request wrong");
  a_irq_masked:
    assert property (bus.wr && bus.addr == SAC_ADDR_IRQEN && !bus.wdata[0] |=> !irq_req)
    else $error("interrupt not masked");
  a_flag_sticky:
    assert property (irq_req && !(bus.wr && (bus.addr == SAC_ADDR_FLAG || bus.addr == SAC_ADDR_IRQEN))
      |=> irq_req)
    else $error("done flag cleared by itself");
  a_res_hi_pad:
    assert property (bus.rd && bus.addr == SAC_ADDR_RES_HI |=> rdata[7:2] == 6'h00)
    else $error("result high byte not right-justified");
endmodule

bind sac_ctrl sac_ctrl_chk chk_u (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .sleep_mode(sleep_mode), .channel_select_field(channel_select_field),
  .die_temperature_channel(die_temperature_channel), .reference_select(reference_select),
  .converter_on(converter_on), .irq_req(irq_req), .wake_req(wake_req));

// ==== tb/sac_ctrl_bench.sv ====
`timescale 1ns/1ps
module sac_ctrl_bench
  import sac_pkg::*;
;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  sac_bus_t bus = '0;
  logic rc_osc_tick = 1'b0;
  logic sleep_mode = 1'b0;
  logic cmp_hi = 1'b0;
  logic [7:0] rdata;
  logic [4:0] chs;
  logic die_ch, sens_on, ref_sel, conv_on, s_h, irq_req, wake_req;
  logic [9:0] dac_code;
  logic [15:0] seed = 16'h0045;
  logic [9:0] vin = 10'h000;
  logic [9:0] prev;
  logic [1:0] rc_cnt = 2'h0;
  logic [7:0] d;
  logic [4:0] ch;
  logic [2:0] cs_t [6] = '{3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int n;
  int n_len;
  int fails = 0;
  int n_checks = 0;

  sac_ctrl #(.CAL_30C(10'h1A5)) dut_u (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .rc_osc_tick(rc_osc_tick), .sleep_mode(sleep_mode), .cmp_hi(cmp_hi),
    .channel_select_field(chs), .die_temperature_channel(die_ch), .temp_sensor_on(sens_on),
    .reference_select(ref_sel), .converter_on(conv_on), .sample_hold(s_h),
    .dac_code(dac_code), .irq_req(irq_req), .wake_req(wake_req));

  always #50 mclk = ~mclk;

  // ideal comparator, so the converged code must equal vin
  always @(posedge mclk)
  begin
    rc_cnt <= (rc_cnt == 2'h2) ? 2'h0 : rc_cnt + 2'h1;
    rc_osc_tick <= (rc_cnt == 2'h2);
    cmp_hi <= (vin >= dac_code);
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // mclk per conversion-clock period; rc is 16 ticks, one tick every 3 mclk
  function automatic int tad_len(input logic [2:0] cs);
    case (cs)
      3'h1: return 8;
      3'h5: return 16;
      3'h2: return 32;
      3'h6: return 64;
      default: return 48;
    endcase
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge mclk);
    bus <= {a, v, 1'b1, 1'b0};
    @(posedge mclk);
    bus <= '0;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    bus <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk);
    bus <= '0;
    // rdata stands until the next edge, so it is taken there
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic rc(input string nm, input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, e, d);
  endtask

  // each poll spans 3 mclk, so the measured length has 3 mclk resolution
  task automatic wait_done();
    n = 3;
    rd(SAC_ADDR_CTRL_A);
    while (d[1] !== 1'b0 && n < 1600)
    begin
      rd(SAC_ADDR_CTRL_A);
      n += 3;
    end
    if (n >= 1600)
    begin
      fails++;
      $display("[FAIL] go clear expected 0 seen 1");
      complete_run();
    end
  endtask

  initial
  begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    for (int a = 0; a < 6; a++)
      rc("reset value", a[3:0], 8'h00);
    rc("unmapped", 4'hF, 8'h00);
    chk("sensor power", 1, sens_on);
    rc("cal high", SAC_ADDR_CAL_HI, 8'h01);
    rc("cal low", SAC_ADDR_CAL_LO, 8'hA5);
    wr(SAC_ADDR_CTRL_A, 8'h03);
    rc("start while off", SAC_ADDR_CTRL_A, 8'h01);
    $display("end of test: reset and enable");
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      vin = seed[9:0];
      ch = (i == 0) ? SAC_CH_TEMP : seed[14:10];
      n_len = 11 * tad_len(cs_t[i]);
      wr(SAC_ADDR_CTRL_B, {1'b0, cs_t[i], 3'h0, i[1]});
      wr(SAC_ADDR_CTRL_A, {1'b0, ch, 2'h1});
      wr(SAC_ADDR_IRQEN, {7'h00, i[0]});
      // outputs of a write settle only after its edge, so look at least one write later
      chk("reference", i[1], ref_sel);
      chk("channel", ch, chs);
      chk("temp channel", ch == SAC_CH_TEMP, die_ch);
      // settling after a channel change is left to software
      repeat (50) @(posedge mclk);
      wr(SAC_ADDR_CTRL_A, {1'b0, ch, 2'h3});
      wait_done();
      chk("control after end", {1'b0, ch, 2'h1}, d);
      chk("length", 1, n >= n_len - 6 && n <= n_len + 8);
      sleep_mode <= seed[15];
      rc("result high", SAC_ADDR_RES_HI, {6'h00, vin[9:8]});
      rc("result low", SAC_ADDR_RES_LO, vin[7:0]);
      rc("done flag", SAC_ADDR_FLAG, 8'h01);
      chk("irq", i[0], irq_req);
      chk("wake", i[0] & seed[15], wake_req);
      sleep_mode <= 1'b0;
      wr(SAC_ADDR_FLAG, 8'h00);
      rc("flag clear", SAC_ADDR_FLAG, 8'h00);
      $display("end of test: convert %0d", i);
    end
    prev = vin;
    vin = ~vin;
    wr(SAC_ADDR_CTRL_B, 8'h10);
    wr(SAC_ADDR_CTRL_A, {1'b0, ch, 2'h3});
    repeat (30) @(posedge mclk);
    wr(SAC_ADDR_CTRL_A, {1'b0, ch, 2'h1});
    rc("abort wait", SAC_ADDR_STATUS, {6'h00, SAC_WAIT});
    // two whole conversion clocks at /8 are 16 mclk, so still waiting here
    repeat (8) @(posedge mclk);
    rc("abort still waiting", SAC_ADDR_STATUS, {6'h00, SAC_WAIT});
    repeat (24) @(posedge mclk);
    rc("abort idle", SAC_ADDR_STATUS, {6'h00, SAC_IDLE});
    chk("sampling", 1, s_h);
    rc("kept high", SAC_ADDR_RES_HI, {6'h00, prev[9:8]});
    rc("kept low", SAC_ADDR_RES_LO, prev[7:0]);
    rc("no flag", SAC_ADDR_FLAG, 8'h00);
    $display("end of test: abort");
    wr(SAC_ADDR_CTRL_A, {1'b0, ch, 2'h3});
    repeat (20) @(posedge mclk);
    reset_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk("off in reset", 0, conv_on);
    reset_n <= 1'b1;
    rc("control cleared", SAC_ADDR_CTRL_A, 8'h00);
    rc("result cleared", SAC_ADDR_RES_LO, 8'h00);
    $display("end of test: reset mid-run");
    complete_run();
  end
endmodule
